// File: core/duf_ctrl.sv
// Update, format and power control of the second 12-bit converter
//
// How it works
// - Enable clear releases the output pin and shuts the converter down.
// - Enable set drives the output pin and keeps the converter running.
// - Control bits six and five read as zero and ignore writes.
// - Mode 00 loads the converter when the high data byte is written.
// - Mode 01 loads the held word only on a third timer overflow.
// - Mode 10 loads the held word only on a fourth timer overflow.
// - Mode 11 loads the held word only on a second timer overflow.
// - Format 000 takes high byte bits 3..0 over the whole low byte.
// - Format 001 takes high byte bits 4..0 over low byte bits 7..1.
// - Format 010 takes high byte bits 5..0 over low byte bits 7..2.
// - Format 011 takes high byte bits 6..0 over low byte bits 7..3.
// - Any format 1xx takes the whole high byte over low bits 7..4.
// - In mode 00 a low byte write waits for the high byte write.
// - In timer modes both bytes are held until the chosen overflow.
`timescale 1ns/1ps

module duf_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Special function register port
    input wire duf_pkg::duf_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Timer overflow pulses
    input wire duf_pkg::duf_ovf_t timer_ovf,
    // Converter side
    output logic [11:0] conv_word,
    output logic out_pin_active,
    output logic conv_shutdown
);
    import duf_pkg::*;

    // ==========================================================
    // Word assembly
    // ==========================================================
    function automatic logic [11:0] assemble(input logic [2:0] fmt,
                                             input logic [7:0] h,
                                             input logic [7:0] l);
        logic [11:0] w;
        w = {h, l[7:4]};
        if (!fmt[2]) begin
            case (fmt)
                DUF_FMT_4_8: w = {h[3:0], l};
                DUF_FMT_5_7: w = {h[4:0], l[7:1]};
                DUF_FMT_6_6: w = {h[5:0], l[7:2]};
                default: w = {h[6:0], l[7:3]};
            endcase
        end
        return w;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    duf_state_t st;
    duf_state_t next_st;
    logic on_page;
    logic sel_ctrl;
    logic sel_hi;
    logic sel_lo;
    logic wr_hi;
    logic load;
    logic [1:0] mode;
    logic [2:0] fmt;
    logic [7:0] src_hi;

    assign mode = st.ctrl[DUF_MODE_HI:DUF_MODE_LO];
    assign fmt = st.ctrl[DUF_FMT_HI:DUF_FMT_LO];

    always_comb begin
        next_st = st;
        on_page = (sfr_req.page == DUF_SFR_PAGE);
        sel_ctrl = on_page && (sfr_req.addr == DUF_ADDR_CTRL);
        sel_hi = on_page && (sfr_req.addr == DUF_ADDR_HIGH);
        sel_lo = on_page && (sfr_req.addr == DUF_ADDR_LOW);
        wr_hi = sfr_req.wr && sel_hi;
        // Pick the event that moves the held bytes into the latch
        case (mode)
            DUF_MODE_WRITE: load = wr_hi;
            DUF_MODE_TMR3: load = timer_ovf.tmr3;
            DUF_MODE_TMR4: load = timer_ovf.tmr4;
            default: load = timer_ovf.tmr2;
        endcase
        // Write mode takes the byte on the bus; timer modes copy what was
        // already held, so a write racing the overflow waits a period
        src_hi = (mode == DUF_MODE_WRITE) ? sfr_req.wdata : st.hi;
        if (load) begin
            next_st.word = assemble(fmt, src_hi, st.lo);
        end
        if (sfr_req.wr) begin
            if (sel_ctrl) begin
                next_st.ctrl = sfr_req.wdata & DUF_CTRL_WMASK;
            end else if (sel_hi) begin
                next_st.hi = sfr_req.wdata;
            end else if (sel_lo) begin
                next_st.lo = sfr_req.wdata;
            end
        end
        if (sfr_req.rd) begin
            if (sel_ctrl) begin
                next_st.rdata = st.ctrl;
            end else if (sel_hi) begin
                next_st.rdata = st.hi;
            end else if (sel_lo) begin
                next_st.rdata = st.lo;
            end else begin
                next_st.rdata = DUF_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st.ctrl <= DUF_CTRL_RESET;
            st.hi <= DUF_DATA_RESET;
            st.lo <= DUF_DATA_RESET;
            st.word <= DUF_WORD_RESET;
            st.rdata <= DUF_UNMAPPED;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign sfr_rdata = st.rdata;
    assign conv_word = st.word;
    assign out_pin_active = st.ctrl[DUF_EN_BIT];
    // Shutdown keeps the analog core at minimum current when unused
    assign conv_shutdown = !st.ctrl[DUF_EN_BIT];

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_off_released;
        (sfr_req.wr && sel_ctrl && !sfr_req.wdata[DUF_EN_BIT])
            |=> !out_pin_active && conv_shutdown;
    endproperty
    a_off_released: assert property (p_off_released)
        else $error("disabled converter still drives its pin");

    property p_on_drives;
        (sfr_req.wr && sel_ctrl && sfr_req.wdata[DUF_EN_BIT])
            |=> out_pin_active && !conv_shutdown;
    endproperty
    a_on_drives: assert property (p_on_drives)
        else $error("enable write did not power the converter");

    property p_unused_zero;
        (sfr_req.rd && sel_ctrl)
            |=> sfr_rdata[DUF_UNUSED_HI:DUF_UNUSED_LO] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused control bits read nonzero");

    property p_write_mode_left;
        (mode == DUF_MODE_WRITE && fmt[2] && wr_hi)
            |=> conv_word == {$past(sfr_req.wdata), $past(st.lo[7:4])};
    endproperty
    a_write_mode_left: assert property (p_write_mode_left)
        else $error("high byte write did not load the converter");

    property p_tmr3_only;
        (mode == DUF_MODE_TMR3 && !timer_ovf.tmr3) |=> $stable(conv_word);
    endproperty
    a_tmr3_only: assert property (p_tmr3_only)
        else $error("word changed without third timer overflow");

    property p_tmr4_only;
        (mode == DUF_MODE_TMR4 && !timer_ovf.tmr4) |=> $stable(conv_word);
    endproperty
    a_tmr4_only: assert property (p_tmr4_only)
        else $error("word changed without fourth timer overflow");

    property p_tmr2_only;
        (mode == DUF_MODE_TMR2 && !timer_ovf.tmr2) |=> $stable(conv_word);
    endproperty
    a_tmr2_only: assert property (p_tmr2_only)
        else $error("word changed without second timer overflow");

    property p_fmt0;
        (load && fmt == DUF_FMT_4_8)
            |=> conv_word == {$past(src_hi[3:0]), $past(st.lo)};
    endproperty
    a_fmt0: assert property (p_fmt0)
        else $error("format 000 assembled wrongly");

    property p_fmt1;
        (load && fmt == DUF_FMT_5_7)
            |=> conv_word == {$past(src_hi[4:0]), $past(st.lo[7:1])};
    endproperty
    a_fmt1: assert property (p_fmt1)
        else $error("format 001 assembled wrongly");

    property p_fmt2;
        (load && fmt == DUF_FMT_6_6)
            |=> conv_word == {$past(src_hi[5:0]), $past(st.lo[7:2])};
    endproperty
    a_fmt2: assert property (p_fmt2)
        else $error("format 010 assembled wrongly");

    property p_fmt3;
        (load && fmt == DUF_FMT_7_5)
            |=> conv_word == {$past(src_hi[6:0]), $past(st.lo[7:3])};
    endproperty
    a_fmt3: assert property (p_fmt3)
        else $error("format 011 assembled wrongly");

    property p_fmt_left;
        (load && fmt[2])
            |=> conv_word == {$past(src_hi), $past(st.lo[7:4])};
    endproperty
    a_fmt_left: assert property (p_fmt_left)
        else $error("format 1xx assembled wrongly");

    sequence s_low_only;
        mode == DUF_MODE_WRITE && sfr_req.wr && sel_lo;
    endsequence

    property p_low_held;
        s_low_only ##1 !wr_hi [*2] |-> $stable(conv_word);
    endproperty
    a_low_held: assert property (p_low_held)
        else $error("low byte write moved the output");

    property p_timer_copy;
        (mode == DUF_MODE_TMR3 && timer_ovf.tmr3 && fmt[2])
            |=> conv_word[11:4] == $past(st.hi);
    endproperty
    a_timer_copy: assert property (p_timer_copy)
        else $error("timer overflow did not copy the held bytes");

    property p_reset_clear;
        $fell(rst) |-> st.ctrl == DUF_CTRL_RESET && conv_shutdown;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control register not cleared by reset");

    property p_word_held;
        !load |=> conv_word == $past(conv_word);
    endproperty
    a_word_held: assert property (p_word_held)
        else $error("latch changed without an update event");

    property p_mode0_no_timer;
        (mode == DUF_MODE_WRITE && !wr_hi) |=> $stable(conv_word);
    endproperty
    a_mode0_no_timer: assert property (p_mode0_no_timer)
        else $error("word changed in write mode without a high write");

    property p_ctrl_mask;
        (sfr_req.wr && sel_ctrl)
            |=> st.ctrl[DUF_UNUSED_HI:DUF_UNUSED_LO] == 2'h0;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask)
        else $error("unused control bits were stored");

    // A byte landing with the overflow must not leak into this copy
    property p_race_held;
        (mode != DUF_MODE_WRITE && load && wr_hi && fmt[2])
            |=> conv_word[11:4] == $past(st.hi);
    endproperty
    a_race_held: assert property (p_race_held)
        else $error("racing high byte leaked into the timer copy");

    property p_timer_writes_held;
        (mode != DUF_MODE_WRITE && sfr_req.wr && (sel_hi || sel_lo)
            && !load) |=> $stable(conv_word);
    endproperty
    a_timer_writes_held: assert property (p_timer_writes_held)
        else $error("byte write moved the word in a timer mode");

    property p_low_stored;
        (sfr_req.wr && sel_lo) |=> st.lo == $past(sfr_req.wdata);
    endproperty
    a_low_stored: assert property (p_low_stored)
        else $error("low byte write was not held");

    property p_high_stored;
        (sfr_req.wr && sel_hi) |=> st.hi == $past(sfr_req.wdata);
    endproperty
    a_high_stored: assert property (p_high_stored)
        else $error("high byte write was not held");

    // ==========================================================
    // Coverage
    // ==========================================================
    c_write_update: cover property (mode == DUF_MODE_WRITE && wr_hi);
    c_tmr3_update: cover property (mode == DUF_MODE_TMR3 && timer_ovf.tmr3);
    c_tmr2_update: cover property (mode == DUF_MODE_TMR2 && timer_ovf.tmr2);
    c_enable: cover property ($rose(out_pin_active));
    c_race_write: cover property (load && wr_hi && mode != DUF_MODE_WRITE);

endmodule // duf_ctrl

// File: core/duf_pkg.sv
// Constants and carrier types for the second converter's update control
package duf_pkg;

    // ==========================================================
    // Special function register map
    // ==========================================================
    localparam logic [7:0] DUF_SFR_PAGE = 8'h01;
    localparam logic [7:0] DUF_ADDR_CTRL = 8'hD4;
    localparam logic [7:0] DUF_ADDR_HIGH = 8'hD3;
    localparam logic [7:0] DUF_ADDR_LOW = 8'hD2;
    localparam logic [7:0] DUF_CTRL_RESET = 8'h00;
    localparam logic [7:0] DUF_CTRL_WMASK = 8'h9F;
    localparam logic [7:0] DUF_DATA_RESET = 8'h00;
    localparam logic [7:0] DUF_UNMAPPED = 8'h00;
    localparam logic [11:0] DUF_WORD_RESET = 12'h000;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int DUF_EN_BIT = 7;
    localparam int DUF_MODE_HI = 4;
    localparam int DUF_MODE_LO = 3;
    localparam int DUF_FMT_HI = 2;
    localparam int DUF_FMT_LO = 0;
    localparam int DUF_UNUSED_HI = 6;
    localparam int DUF_UNUSED_LO = 5;

    // Update modes
    localparam logic [1:0] DUF_MODE_WRITE = 2'h0;
    localparam logic [1:0] DUF_MODE_TMR3 = 2'h1;
    localparam logic [1:0] DUF_MODE_TMR4 = 2'h2;
    localparam logic [1:0] DUF_MODE_TMR2 = 2'h3;

    // Data formats; any code with the top bit set is left justified
    localparam logic [2:0] DUF_FMT_4_8 = 3'h0;
    localparam logic [2:0] DUF_FMT_5_7 = 3'h1;
    localparam logic [2:0] DUF_FMT_6_6 = 3'h2;
    localparam logic [2:0] DUF_FMT_7_5 = 3'h3;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } duf_sfr_req_t;

    typedef struct packed {
        logic tmr2;
        logic tmr3;
        logic tmr4;
    } duf_ovf_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [11:0] word;
        logic [7:0] rdata;
    } duf_state_t;

endpackage

// File: dv/tb_duf_ctrl.sv
// Self-checking bench for the second converter's update control
`timescale 1ns/1ps

module tb_duf_ctrl;
    import duf_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    typedef struct packed {
        logic [2:0] fmt;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [11:0] word;
    } duf_row_t;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    duf_sfr_req_t req = '0;
    duf_ovf_t ovf = '0;
    logic [7:0] rdata;
    logic [11:0] word;
    logic pin_on;
    logic shut;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [11:0] prev;
    logic [2:0] sel;
    logic [7:0] hv;
    duf_row_t rows [8];

    always #5 clk_sys = ~clk_sys;

    duf_ctrl i_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .sfr_req(req),
        .sfr_rdata(rdata),
        .timer_ovf(ovf),
        .conv_word(word),
        .out_pin_active(pin_on),
        .conv_shutdown(shut)
    );

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Strobes stay up across back-to-back calls; idle drops them
    task automatic acc(input logic w, input logic r,
                       input logic [7:0] a, input logic [7:0] d);
        req.page = DUF_SFR_PAGE;
        req.addr = a;
        req.wr = w;
        req.rd = r;
        req.wdata = d;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic idle;
        req.wr = 1'b0;
        req.rd = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, a, 8'h00);
        chk({4'h0, rdata}, {4'h0, exp});
        idle;
    endtask

    task automatic tick(input duf_ovf_t v);
        ovf = v;
        @(posedge clk_sys);
        #1;
        ovf = '0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run needs about a hundred cycles; this cuts a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            results;
        end
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        // Every row but rows[5] sets ignored byte bits so a wrong slice shows up
        rows[0] = '{3'h0, 8'hA5, 8'h3C, 12'h53C};
        rows[1] = '{3'h1, 8'hF3, 8'hA5, 12'h9D2};
        rows[2] = '{3'h2, 8'hC7, 8'hB6, 12'h1ED};
        rows[3] = '{3'h3, 8'h5A, 8'hE9, 12'hB5D};
        rows[4] = '{3'h4, 8'h81, 8'h7F, 12'h817};
        rows[5] = '{3'h5, 8'h3C, 8'hC0, 12'h3CC};
        rows[6] = '{3'h6, 8'hFF, 8'h0F, 12'hFF0};
        rows[7] = '{3'h7, 8'h12, 8'hF3, 12'h12F};
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(word, DUF_WORD_RESET);
        chk({10'h0, pin_on, shut}, 12'h001);
        rd_chk(DUF_ADDR_CTRL, DUF_CTRL_RESET);
        prev = DUF_WORD_RESET;
        foreach (rows[i]) begin
            acc(1'b1, 1'b0, DUF_ADDR_CTRL, {5'h00, rows[i].fmt});
            acc(1'b1, 1'b0, DUF_ADDR_LOW, rows[i].lo);
            repeat (2) idle;
            chk(word, prev);
            acc(1'b1, 1'b0, DUF_ADDR_HIGH, rows[i].hi);
            idle;
            chk(word, rows[i].word);
            prev = rows[i].word;
        end
        tick(3'b111);
        chk(word, prev);
        rd_chk(DUF_ADDR_HIGH, rows[7].hi);
        rd_chk(DUF_ADDR_LOW, rows[7].lo);
        acc(1'b1, 1'b0, DUF_ADDR_CTRL, 8'hFF);
        idle;
        rd_chk(DUF_ADDR_CTRL, 8'h9F);
        chk({10'h0, pin_on, shut}, 12'h002);
        // Last read left nonzero data, so a stale answer would show
        rd_chk(8'hD5, DUF_UNMAPPED);
        acc(1'b1, 1'b0, DUF_ADDR_CTRL, 8'h60);
        idle;
        rd_chk(DUF_ADDR_CTRL, 8'h00);
        chk({10'h0, pin_on, shut}, 12'h001);
        req = '{8'h00, DUF_ADDR_CTRL, 1'b1, 1'b0, 8'h80};
        @(posedge clk_sys);
        #1;
        idle;
        chk({10'h0, pin_on, shut}, 12'h001);
        for (int m = 1; m < 4; m++) begin
            sel = (m == 1) ? 3'b010 : (m == 2) ? 3'b001 : 3'b100;
            hv = 8'hA0 + m[7:0];
            acc(1'b1, 1'b0, DUF_ADDR_CTRL, {3'b000, m[1:0], 3'b100});
            acc(1'b1, 1'b0, DUF_ADDR_LOW, 8'h5F);
            acc(1'b1, 1'b0, DUF_ADDR_HIGH, hv);
            idle;
            chk(word, prev);
            tick(~sel);
            chk(word, prev);
            tick(sel);
            prev = {hv, 4'h5};
            chk(word, prev);
        end
        // High byte written in the overflow cycle waits for the next one
        acc(1'b1, 1'b0, DUF_ADDR_LOW, 8'hC0);
        req.addr = DUF_ADDR_HIGH;
        req.wdata = 8'h77;
        ovf = 3'b100;
        @(posedge clk_sys);
        #1;
        ovf = '0;
        idle;
        chk(word, 12'hA3C);
        tick(3'b100);
        chk(word, 12'h77C);
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        chk(word, DUF_WORD_RESET);
        rst = 1'b0;
        rd_chk(DUF_ADDR_CTRL, DUF_CTRL_RESET);
        results;
    end

endmodule // tb_duf_ctrl
